// ---- src/wdt_consts.vh ----
// Constants for the watchdog timer: register offsets, field positions,
// reset values and divide ratios.
// Included by the watchdog top, the checker and the testbench by its bare name.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// Register byte offsets
`define WDT_ADDR_W          8
`define WDT_OFS_RSTCTL      8'h00
`define WDT_OFS_STAT        8'h04
`define WDT_OFS_MASK        8'h08
`define WDT_OFS_CNT         8'h0C

// Reset control register fields
`define WDT_RSTCTL_IDLE     2
`define WDT_RSTCTL_SLEEP    3
`define WDT_RSTCTL_TMO      4
`define WDT_RSTCTL_SWEN     5
`define WDT_RSTCTL_RST      6'h00

// Interrupt status and mask fields
`define WDT_INT_TMO_RST     0
`define WDT_INT_WAKE        1
`define WDT_INT_W           2
`define WDT_INT_RST         2'h0

// Oscillator and divide ratios (ratio minus one where a divider takes it)
`define WDT_RCOSC_HZ        512000
`define WDT_RCOSC_DIV_M1    2'h3
`define WDT_PSA_W           9
`define WDT_PSA_M1_1        9'h000
`define WDT_PSA_M1_8        9'h007
`define WDT_PSA_M1_64       9'h03F
`define WDT_PSA_M1_512      9'h1FF
`define WDT_PSB_W           4
`define WDT_CNT_W           8
`define WDT_CNT_MAX         8'hFF

// Power-save mode encodings
`define WDT_MODE_RUN        2'h0
`define WDT_MODE_SLEEP      2'h1
`define WDT_MODE_IDLE       2'h2

`endif

// ---- src/wdt_div.v ----
// Divider stage: emits a one-cycle pulse on every (ratio_m1+1)-th enable.
// Assumes enables and clear come from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module wdt_div #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         nrst,
    // Control
    input  wire         clr,
    input  wire         en,
    input  wire [W-1:0] ratio_m1,
    // Output pulse
    output wire         tick
);

    reg  [W-1:0] cnt_q;
    reg  [W-1:0] cnt_d;

    // Pulse is combinational so cascaded stages advance in the same cycle
    assign tick = en & ~clr & (cnt_q == ratio_m1);

    always @*
    begin
        cnt_d = cnt_q;
        if (clr)
            cnt_d = {W{1'b0}};
        else if (tick)
            cnt_d = {W{1'b0}};
        else if (en)
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    end

    always @(posedge clk_sys)
    begin
        if (!nrst)
            cnt_q <= {W{1'b0}};
        else
            cnt_q <= cnt_d;
    end

endmodule

`default_nettype wire

// ---- src/wdt_top.v ----
// Watchdog timer: low-power RC tick divided by four, two cascaded
// prescalers, an 8-bit counter, reset/wake requests and status bits.
// Assumes the core reset logic pulses dev_reset for device resets other
// than power-on, and that nrst is the power-on reset on clk_sys.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.vh"

module wdt_top (
    // Clock and reset
    input  wire                    clk_sys,
    input  wire                    nrst,
    // Oscillator pin
    input  wire                    low_power_rc_osc,
    // Nonvolatile configuration
    input  wire                    cfg_watchdog_enable,
    input  wire [1:0]              cfg_prescale_first_sel,
    input  wire [3:0]              cfg_prescale_second_sel,
    // Core events
    input  wire                    dev_reset,
    input  wire                    clear_watchdog_instr,
    input  wire                    power_save_instr,
    input  wire                    power_save_idle,
    input  wire                    other_wake,
    // Requests to the core
    output reg                     wdt_reset_req_q,
    output reg                     wdt_wake_req_q,
    // Register port
    input  wire [`WDT_ADDR_W-1:0]  reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata_q,
    // Interrupt
    output reg                     irq_q
);

    // Prescaler A ratio decode
    function [`WDT_PSA_W-1:0] psa_ratio_m1;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    psa_ratio_m1 = `WDT_PSA_M1_1;
                2'h1:    psa_ratio_m1 = `WDT_PSA_M1_8;
                2'h2:    psa_ratio_m1 = `WDT_PSA_M1_64;
                default: psa_ratio_m1 = `WDT_PSA_M1_512;
            endcase
        end
    endfunction

    // Power-save states
    localparam [1:0] MODE_RUN   = 2'h0;
    localparam [1:0] MODE_SLEEP = 2'h1;
    localparam [1:0] MODE_IDLE  = 2'h2;

    reg                    osc_s1_q;
    reg                    osc_s2_q;
    reg                    osc_s3_q;
    reg                    cfg_en_q;
    reg  [1:0]             cfg_psa_q;
    reg  [3:0]             cfg_psb_q;
    reg                    sw_en_q;
    reg                    sw_en_d;
    reg  [2:0]             rflags_q;
    reg  [2:0]             rflags_d;
    reg  [1:0]             mode_q;
    reg  [1:0]             mode_d;
    reg  [`WDT_CNT_W-1:0]  cnt_q;
    reg  [`WDT_CNT_W-1:0]  cnt_d;
    reg  [`WDT_INT_W-1:0]  stat_q;
    reg  [`WDT_INT_W-1:0]  stat_d;
    reg  [`WDT_INT_W-1:0]  mask_q;
    reg  [`WDT_INT_W-1:0]  mask_d;
    reg  [31:0]            rdata_d;
    wire                   osc_rise;
    wire                   tick_128k;
    wire                   tick_a;
    wire                   tick_b;
    wire                   wdt_on;
    wire                   wdt_clr;
    wire                   timeout;
    wire                   wr_rstctl;
    wire                   wr_stat;
    wire                   wr_mask;

    // Oscillator pin is asynchronous; only the second and third stages feed logic
    always @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= low_power_rc_osc;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // Rising edges of the slow pin become single-cycle enables
    assign osc_rise = osc_s2_q & ~osc_s3_q;

    // Configuration is sampled only while in reset, so run-time changes on
    // the pins cannot alter enable or timeout
    always @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cfg_en_q  <= cfg_watchdog_enable;
            cfg_psa_q <= cfg_prescale_first_sel;
            cfg_psb_q <= cfg_prescale_second_sel;
        end
    end

    assign wdt_on  = cfg_en_q | sw_en_q;
    // Disabled watchdog is also held clear so enabling starts a full period
    assign wdt_clr = dev_reset | power_save_instr | clear_watchdog_instr | ~wdt_on;

    // Divide-by-four stays free running: it belongs to the clock source
    wdt_div #(
        .W        (2)
    ) u_osc_div (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clr      (1'b0),
        .en       (osc_rise),
        .ratio_m1 (`WDT_RCOSC_DIV_M1),
        .tick     (tick_128k)
    );

    wdt_div #(
        .W        (`WDT_PSA_W)
    ) u_psa (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clr      (wdt_clr),
        .en       (tick_128k),
        .ratio_m1 (psa_ratio_m1(cfg_psa_q)),
        .tick     (tick_a)
    );

    wdt_div #(
        .W        (`WDT_PSB_W)
    ) u_psb (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clr      (wdt_clr),
        .en       (tick_a),
        .ratio_m1 (cfg_psb_q),
        .tick     (tick_b)
    );

    // Period = 256 ticks of 128 kHz times both ratios
    assign timeout = tick_b & (cnt_q == `WDT_CNT_MAX);

    always @*
    begin
        cnt_d = cnt_q;
        if (wdt_clr)
            cnt_d = {`WDT_CNT_W{1'b0}};
        else if (tick_b)
            cnt_d = cnt_q + 8'h01;
    end

    // Power-save mode tracking; counting does not depend on the mode
    always @*
    begin
        mode_d = mode_q;
        // Any wake returns to run, so a later timeout resets instead of waking
        case (mode_q)
            MODE_RUN:
                if (power_save_instr)
                    mode_d = power_save_idle ? MODE_IDLE : MODE_SLEEP;
            MODE_SLEEP,
            MODE_IDLE:
                if (timeout | other_wake | dev_reset)
                    mode_d = MODE_RUN;
            default:
                mode_d = MODE_RUN;
        endcase
    end

    assign wr_rstctl = reg_wr & (reg_addr == `WDT_OFS_RSTCTL);
    assign wr_stat = reg_wr & (reg_addr == `WDT_OFS_STAT);
    assign wr_mask = reg_wr & (reg_addr == `WDT_OFS_MASK);

    // Flags: software may write them, a hardware set in the same cycle wins
    always @*
    begin
        sw_en_d  = sw_en_q;
        rflags_d = rflags_q;
        if (wr_rstctl)
        begin
            sw_en_d  = reg_wdata[`WDT_RSTCTL_SWEN];
            rflags_d = reg_wdata[`WDT_RSTCTL_TMO:`WDT_RSTCTL_IDLE];
        end
        if (dev_reset)
            sw_en_d = 1'b0;
        if (timeout)
        begin
            rflags_d[`WDT_RSTCTL_TMO-`WDT_RSTCTL_IDLE] = 1'b1;
            if (mode_q == MODE_SLEEP)
                rflags_d[`WDT_RSTCTL_SLEEP-`WDT_RSTCTL_IDLE] = 1'b1;
            if (mode_q == MODE_IDLE)
                rflags_d[0] = 1'b1;
        end
    end

    always @*
    begin
        stat_d = stat_q;
        if (wr_stat)
            stat_d = stat_q & ~reg_wdata[`WDT_INT_W-1:0];
        // Event bits split by what the timeout did to the core
        if (timeout & (mode_q == MODE_RUN))
            stat_d[`WDT_INT_TMO_RST] = 1'b1;
        if (timeout & (mode_q != MODE_RUN))
            stat_d[`WDT_INT_WAKE] = 1'b1;
    end

    always @*
    begin
        mask_d = mask_q;
        if (wr_mask)
            mask_d = reg_wdata[`WDT_INT_W-1:0];
    end

    // Read data stands only in the cycle after the strobe
    always @*
    begin
        rdata_d = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                `WDT_OFS_RSTCTL:
                begin
                    rdata_d[`WDT_RSTCTL_SWEN] = sw_en_q;
                    rdata_d[`WDT_RSTCTL_TMO:`WDT_RSTCTL_IDLE] = rflags_q;
                end
                `WDT_OFS_STAT: rdata_d[`WDT_INT_W-1:0] = stat_q;
                `WDT_OFS_MASK: rdata_d[`WDT_INT_W-1:0] = mask_q;
                `WDT_OFS_CNT:  rdata_d[`WDT_CNT_W-1:0] = cnt_q;
                default:       rdata_d = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cnt_q           <= {`WDT_CNT_W{1'b0}};
            mode_q          <= MODE_RUN;
            sw_en_q         <= 1'b0;
            rflags_q        <= 3'h0;
            stat_q          <= `WDT_INT_RST;
            mask_q          <= `WDT_INT_RST;
            reg_rdata_q     <= 32'h00000000;
            irq_q           <= 1'b0;
            wdt_reset_req_q <= 1'b0;
            wdt_wake_req_q  <= 1'b0;
        end
        else
        begin
            cnt_q           <= cnt_d;
            mode_q          <= mode_d;
            sw_en_q         <= sw_en_d;
            rflags_q        <= rflags_d;
            stat_q          <= stat_d;
            mask_q          <= mask_d;
            reg_rdata_q     <= rdata_d;
            irq_q           <= |(stat_q & mask_q);
            // Requests are single-cycle pulses; the core must act on them at once
            wdt_reset_req_q <= timeout & (mode_q == MODE_RUN);
            wdt_wake_req_q  <= timeout & (mode_q != MODE_RUN);
        end
    end

endmodule

`default_nettype wire

// ---- verif/wdt_props_properties.sv ----
// Checker for the watchdog top: request pulses, clears and read port.
// Assumes it is bound to wdt_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.vh"

module wdt_props (
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    // Core events
    input wire logic                   dev_reset,
    input wire logic                   clear_watchdog_instr,
    input wire logic                   power_save_instr,
    // Requests, register port, interrupt
    input wire logic                   wdt_reset_req_q,
    input wire logic                   wdt_wake_req_q,
    input wire logic [`WDT_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata_q,
    input wire logic                   irq_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // A cleared counter needs 256 ticks before it can time out again
    sequence s_quiet8;
        !wdt_reset_req_q [*8];
    endsequence
    sequence s_clr_read;
        clear_watchdog_instr ##2 (reg_rd && reg_addr == `WDT_OFS_CNT);
    endsequence

    property p_clr_quiet;
        clear_watchdog_instr |=> s_quiet8;
    endproperty
    property p_dev_quiet;
        dev_reset |=> s_quiet8;
    endproperty
    property p_ps_quiet;
        power_save_instr |=> s_quiet8;
    endproperty
    property p_rst_pulse;
        wdt_reset_req_q |=> !wdt_reset_req_q;
    endproperty
    property p_wake_pulse;
        wdt_wake_req_q |=> !wdt_wake_req_q;
    endproperty
    property p_excl;
        !(wdt_reset_req_q && wdt_wake_req_q);
    endproperty
    property p_clr_cnt;
        s_clr_read |=> reg_rdata_q <= 32'h1;
    endproperty
    property p_rd_idle;
        !reg_rd |=> reg_rdata_q == 32'h0;
    endproperty
    property p_start;
        $rose(nrst) |-> !wdt_reset_req_q && !wdt_wake_req_q && !irq_q;
    endproperty

    a_clr_quiet: assert property (p_clr_quiet) else $error("reset request after clear");
    a_dev_quiet: assert property (p_dev_quiet) else $error("reset request after reset");
    a_ps_quiet: assert property (p_ps_quiet) else $error("reset request in power save");
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake request too long");
    a_excl: assert property (p_excl) else $error("reset and wake together");
    a_clr_cnt: assert property (p_clr_cnt) else $error("counter not cleared");
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    a_start: assert property (p_start) else $error("outputs busy after reset");
endmodule

bind wdt_top wdt_props wdt_props_inst (
    .clk_sys(clk_sys), .nrst(nrst), .dev_reset(dev_reset),
    .clear_watchdog_instr(clear_watchdog_instr), .power_save_instr(power_save_instr),
    .wdt_reset_req_q(wdt_reset_req_q), .wdt_wake_req_q(wdt_wake_req_q),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q)
);
`default_nettype wire

// ---- verif/wdt_core_model.sv ----
// Core-side model: RC oscillator pin and device reset on request.
// Assumes clk_sys at 25 MHz; pin toggles every two cycles.
`timescale 1ns/10ps
`default_nettype none

module wdt_core_model (
    // Clock
    input  wire logic clk_sys,
    // Watchdog side
    input  wire logic wdt_reset_req_q,
    output var  logic low_power_rc_osc,
    output var  logic dev_reset
);
    logic [1:0] ph_q;
    initial
    begin
        ph_q = 2'h0;
        low_power_rc_osc = 1'b0;
        dev_reset = 1'b0;
    end
    // Fast pin keeps runs short; timing scales with the pin, not clk_sys
    always @(posedge clk_sys)
    begin
        ph_q <= ph_q + 2'h1;
        low_power_rc_osc <= ph_q[1];
        dev_reset <= wdt_reset_req_q;
    end
endmodule
`default_nettype wire

// ---- verif/test_watchdog_timer_with_prescalers.sv ----
// Testbench for the watchdog top: periods, clears, wake, software enable.
// Assumes the core model answers reset requests and drives the pin.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.vh"

module test_watchdog_timer_with_prescalers;
    logic        clk_sys, nrst, cfg_en, clr, ps, ps_idle, wr, rd, rst_req, wake_req, irq, osc, dev_rst;
    logic        owake;
    logic [1:0]  cfg_a;
    logic [3:0]  cfg_b;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    int          n_errors, n_tests;

    wdt_top wdt_top_inst (
        .clk_sys(clk_sys), .nrst(nrst), .low_power_rc_osc(osc), .cfg_watchdog_enable(cfg_en),
        .cfg_prescale_first_sel(cfg_a), .cfg_prescale_second_sel(cfg_b), .dev_reset(dev_rst),
        .clear_watchdog_instr(clr), .power_save_instr(ps), .power_save_idle(ps_idle),
        .other_wake(owake), .wdt_reset_req_q(rst_req), .wdt_wake_req_q(wake_req),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdata),
        .irq_q(irq)
    );
    wdt_core_model wdt_core_model_inst (
        .clk_sys(clk_sys), .wdt_reset_req_q(rst_req), .low_power_rc_osc(osc), .dev_reset(dev_rst)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("Checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic do_reset(input logic en, input logic [1:0] a, input logic [3:0] b);
        @(posedge clk_sys);
        nrst <= 1'b0;
        cfg_en <= en;
        cfg_a <= a;
        cfg_b <= b;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pulse_clr;
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
    endtask

    // Waits for either request; a hang shows up as a wrong period
    task automatic t_period(input string nm, input int exp, input logic exp_wake);
        int n;
        n = 0;
        while (rst_req !== 1'b1 && wake_req !== 1'b1 && n < 40000)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        check({nm, " wake"}, wake_req, exp_wake);
        check({nm, " period"}, n >= exp - 20 && n <= exp + 20, 1);
    endtask

    task automatic t_run;
        rd_reg(`WDT_OFS_RSTCTL, v);
        check("rstctl reset", v, 0);
        rd_reg(8'h10, v);
        check("unmapped", v, 0);
        wr_reg(`WDT_OFS_MASK, 3);
        pulse_clr;
        t_period("run", 4096, 0);
        repeat (3) @(posedge clk_sys);
        #1 check("irq set", irq, 1);
        rd_reg(`WDT_OFS_RSTCTL, v);
        check("rstctl tmo", v, 32'h10);
        rd_reg(`WDT_OFS_STAT, v);
        check("stat run", v, 1);
        wr_reg(`WDT_OFS_STAT, 1);
        repeat (2) @(posedge clk_sys);
        #1 check("irq clear", irq, 0);
        repeat (600) @(posedge clk_sys);
        pulse_clr;
        rd_reg(`WDT_OFS_CNT, v);
        check("cnt clear", v <= 1, 1);
        $display("test run done");
    endtask

    task automatic t_sleep(input logic idle);
        wr_reg(`WDT_OFS_RSTCTL, 0);
        wr_reg(`WDT_OFS_STAT, 3);
        @(posedge clk_sys);
        ps <= 1'b1;
        ps_idle <= idle;
        @(posedge clk_sys);
        ps <= 1'b0;
        t_period("save", 4096, 1);
        rd_reg(`WDT_OFS_RSTCTL, v);
        check("rstctl wake", v, idle ? 32'h14 : 32'h18);
        rd_reg(`WDT_OFS_STAT, v);
        check("stat wake", v, 2);
        $display("test sleep done");
    endtask

    // A wake from elsewhere returns to run: the next timeout must reset, not wake
    task automatic t_other;
        @(posedge clk_sys);
        ps <= 1'b1;
        ps_idle <= 1'b0;
        @(posedge clk_sys);
        ps <= 1'b0;
        owake <= 1'b1;
        @(posedge clk_sys);
        owake <= 1'b0;
        t_period("other", 4096, 0);
        $display("test other done");
    endtask

    task automatic t_soft;
        do_reset(0, 0, 1);
        repeat (600) @(posedge clk_sys);
        rd_reg(`WDT_OFS_CNT, v);
        check("cnt off", v, 0);
        wr_reg(`WDT_OFS_RSTCTL, 32'h20);
        pulse_clr;
        t_period("soft", 8192, 0);
        repeat (3) @(posedge clk_sys);
        rd_reg(`WDT_OFS_RSTCTL, v);
        check("swen cleared", v, 32'h10);
        do_reset(1, 1, 0);
        pulse_clr;
        t_period("presc a", 32768, 0);
        $display("test soft done");
    endtask

    initial
    begin
        #(40 * 80000);
        n_errors++;
        conclude;
    end

    initial
    begin
        n_errors = 0;
        n_tests = 0;
        {nrst, clr, ps, ps_idle, wr, rd, owake} = 7'h00;
        addr = 8'h00;
        wdata = 32'h0;
        do_reset(1, 0, 0);
        t_run;
        t_sleep(0);
        t_sleep(1);
        t_other;
        t_soft;
        conclude;
    end
endmodule
`default_nettype wire
